//--- inc/pms_pkg.sv
// Shared constants for the station management link and its two ends
package pms_pkg;
    // Frame layout
    localparam int PMS_PRE_LEN = 32;
    localparam logic [5:0] PMS_PRE_FULL = 6'h20;
    localparam logic [1:0] PMS_START = 2'h1;
    localparam logic [1:0] PMS_OP_RD = 2'h2;
    localparam logic [1:0] PMS_OP_WR = 2'h1;
    localparam logic [1:0] PMS_TA_WR = 2'h2;
    localparam logic [1:0] PMS_TA_IDLE = 2'h3;
    localparam logic [1:0] PMS_PHY_HI = 2'h0;
    localparam logic [5:0] PMS_FRAME_LAST = 6'h3F;
    localparam logic [5:0] PMS_RD_DRV_BITS = 6'h2E;
    localparam logic [5:0] PMS_RD_DATA_FIRST = 6'h30;
    localparam logic [4:0] PMS_HDR_LAST = 5'h09;
    localparam logic [4:0] PMS_DATA_LAST = 5'h0F;
    // Device register space
    localparam logic [4:0] PMS_REG_EXT_CTL = 5'h0B;
    localparam logic [4:0] PMS_REG_EXT_WR = 5'h0C;
    localparam logic [4:0] PMS_REG_EXT_RD = 5'h0D;
    localparam logic [4:0] PMS_REG_IRQ = 5'h1B;
    localparam logic [4:0] PMS_REG_PHY_CTL = 5'h1F;
    localparam int PMS_POL_BIT = 14;
    localparam int PMS_EXT_WR_BIT = 15;
    localparam logic [15:0] PMS_REG_RST = 16'h0000;
    // Timing: 10 MHz system clock, 800 ns management clock
    localparam int PMS_CLK_NS = 100;
    localparam int PMS_MDC_NS = 800;
    localparam logic [3:0] PMS_MDC_HALF = 4'(PMS_MDC_NS / (2 * PMS_CLK_NS));
    // Controller register offsets
    localparam logic [2:0] PMS_H_CMD = 3'h0;
    localparam logic [2:0] PMS_H_WDATA = 3'h1;
    localparam logic [2:0] PMS_H_RDATA = 3'h2;
    localparam logic [2:0] PMS_H_STATUS = 3'h3;
    localparam logic [2:0] PMS_H_ISTAT = 3'h4;
    localparam logic [2:0] PMS_H_IMASK = 3'h5;
    localparam logic [2:0] PMS_H_CFG = 3'h6;
    localparam int PMS_CMD_RD_BIT = 15;
    localparam int PMS_IS_DONE = 0;
    localparam int PMS_IS_PHY = 1;
endpackage : pms_pkg

//--- inc/pms_if.sv
// Two-wire management link joining controller and device
`timescale 1ns/1ns
interface pms_if;
    logic mdc;
    logic ctl_mdio_o;
    logic ctl_mdio_oe;
    logic dev_mdio_o;
    logic dev_mdio_oe;
    logic irq_pin;
    logic mdio;
    // Shared line with pull-up: reads high when nobody drives
    assign mdio = ctl_mdio_oe ? ctl_mdio_o : (dev_mdio_oe ? dev_mdio_o : 1'b1);
    modport dev_mp(input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe,
                   output irq_pin);
    modport ctl_mp(output mdc, output ctl_mdio_o, output ctl_mdio_oe, input mdio,
                   input irq_pin);
endinterface : pms_if

//--- rtl/pms_dev.sv
// Management slave of the transceiver with its interrupt logic
//
// Added by the designer: the address strap port.
`timescale 1ns/1ns
module pms_dev
    import pms_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, high
    pms_if.dev_mp link, // Management link
    input wire logic [2:0] address_strap_pins_i, // Board address strap
    input wire logic [7:0] irq_event_i, // Condition pulses
    output logic [15:0] phy_control_o // Control register
);

    typedef enum logic [2:0] {
        PMS_D_PRE,
        PMS_D_START,
        PMS_D_OP,
        PMS_D_HDR,
        PMS_D_TA,
        PMS_D_DATA
    } pms_dstate_t;

    typedef struct packed {
        logic [2:0] mdc_s;
        logic [1:0] mdio_s;
        logic [2:0] strap_a;
        logic [2:0] strap_b;
        logic [2:0] strap_q;
        logic strap_vld;
        logic [1:0] strap_age;
        pms_dstate_t st;
        logic [5:0] cnt;
        logic [1:0] op;
        logic [9:0] hdr;
        logic [4:0] reg_a;
        logic [15:0] data;
        logic drv_o;
        logic drv_oe;
        logic irq_pin;
        logic [31:0][15:0] regs;
        logic [7:0][15:0] ext;
    } pms_dev_st_t;

    pms_dev_st_t q;
    pms_dev_st_t d;

    logic mdc_rise;
    logic bit_in;
    logic [9:0] hdr_full;
    logic [15:0] wr_full;
    logic [2:0] ext_idx;
    logic irq_act;

    // Edge of the synchronised clock; the first stage feeds nothing else
    assign mdc_rise = q.mdc_s[1] & ~q.mdc_s[2];
    assign bit_in = q.mdio_s[1];
    assign hdr_full = {q.hdr[8:0], bit_in};
    assign wr_full = {q.data[14:0], bit_in};
    assign ext_idx = q.regs[PMS_REG_EXT_CTL][2:0];
    assign irq_act = |(q.regs[PMS_REG_IRQ][15:8] & q.regs[PMS_REG_IRQ][7:0]);

    // Next state
    always_comb begin
        d = q;
        d.mdc_s = {q.mdc_s[1:0], link.mdc};
        d.mdio_s = {q.mdio_s[0], link.mdio};
        // Strap caught after reset release, through two stages first
        d.strap_a = address_strap_pins_i;
        d.strap_b = q.strap_a;
        // Latch only once the second stage holds the pins, not its reset zero
        if (!q.strap_vld) begin
            d.strap_age = q.strap_age + 2'h1;
            if (q.strap_age == 2'h2) begin
                d.strap_q = q.strap_b;
                d.strap_vld = 1'b1;
            end
        end
        // Bits are taken only on rising MDC edges
        if (mdc_rise) begin
            case (q.st)
                PMS_D_PRE: begin
                    if (bit_in) begin
                        if (q.cnt != PMS_PRE_FULL) begin
                            d.cnt = q.cnt + 6'h01;
                        end
                    end else if (q.cnt == PMS_PRE_FULL) begin
                        // First half of the start pattern seen
                        d.st = PMS_D_START;
                        d.cnt = 6'h00;
                    end else begin
                        d.cnt = 6'h00;
                    end
                end
                PMS_D_START: begin
                    d.cnt = 6'h00;
                    d.st = bit_in ? PMS_D_OP : PMS_D_PRE;
                end
                PMS_D_OP: begin
                    d.op = {q.op[0], bit_in};
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt[0]) begin
                        d.st = PMS_D_HDR;
                        d.cnt = 6'h00;
                    end
                end
                PMS_D_HDR: begin
                    d.hdr = hdr_full;
                    d.cnt = q.cnt + 6'h01;
                    if (q.cnt[4:0] == PMS_HDR_LAST) begin
                        d.cnt = 6'h00;
                        d.reg_a = hdr_full[4:0];
                        // Foreign address or bad opcode: back to hunting
                        if (!q.strap_vld || hdr_full[9:5] != {PMS_PHY_HI, q.strap_q}
                            || (q.op != PMS_OP_RD && q.op != PMS_OP_WR)) begin
                            d.st = PMS_D_PRE;
                        end else begin
                            d.st = PMS_D_TA;
                            if (q.op == PMS_OP_RD) begin
                                if (hdr_full[4:0] == PMS_REG_EXT_RD) begin
                                    d.data = q.ext[ext_idx];
                                end else begin
                                    d.data = q.regs[hdr_full[4:0]];
                                end
                                // Status flags go once their value is captured
                                if (hdr_full[4:0] == PMS_REG_IRQ) begin
                                    d.regs[PMS_REG_IRQ][7:0] = 8'h00;
                                end
                            end
                        end
                    end
                end
                PMS_D_TA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.op == PMS_OP_RD) begin
                        if (!q.cnt[0]) begin
                            // Controller let go in the first bit; drive zero
                            d.drv_oe = 1'b1;
                            d.drv_o = 1'b0;
                        end else begin
                            d.drv_o = q.data[15];
                            d.data = {q.data[14:0], 1'b0};
                        end
                    end
                    if (q.cnt[0]) begin
                        d.st = PMS_D_DATA;
                        d.cnt = 6'h00;
                    end
                end
                PMS_D_DATA: begin
                    d.cnt = q.cnt + 6'h01;
                    if (q.op == PMS_OP_RD) begin
                        // Most significant bit first
                        d.drv_o = q.data[15];
                        d.data = {q.data[14:0], 1'b0};
                    end else begin
                        d.data = wr_full;
                    end
                    if (q.cnt[4:0] == PMS_DATA_LAST) begin
                        d.st = PMS_D_PRE;
                        d.cnt = 6'h00;
                        d.drv_oe = 1'b0;
                        d.drv_o = 1'b0;
                        if (q.op == PMS_OP_WR) begin
                            if (q.reg_a == PMS_REG_IRQ) begin
                                // Only enables are writable
                                d.regs[PMS_REG_IRQ][15:8] = wr_full[15:8];
                            end else if (q.reg_a == PMS_REG_EXT_WR) begin
                                d.regs[PMS_REG_EXT_WR] = wr_full;
                                if (q.regs[PMS_REG_EXT_CTL][PMS_EXT_WR_BIT]) begin
                                    d.ext[ext_idx] = wr_full;
                                end
                            end else if (q.reg_a != PMS_REG_EXT_RD) begin
                                d.regs[q.reg_a] = wr_full;
                            end
                        end
                    end
                end
                default: begin
                    d.st = PMS_D_PRE;
                    d.cnt = 6'h00;
                end
            endcase
        end
        // A new condition wins over a clear in the same cycle
        d.regs[PMS_REG_IRQ][7:0] = d.regs[PMS_REG_IRQ][7:0] | irq_event_i;
        // Pin level follows the programmed polarity
        if (q.regs[PMS_REG_PHY_CTL][PMS_POL_BIT]) begin
            d.irq_pin = irq_act;
        end else begin
            d.irq_pin = ~irq_act;
        end
    end

    // State register; reset leaves the pin idle for active low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.irq_pin <= 1'b1;
            q.regs <= {32{PMS_REG_RST}};
            q.st <= PMS_D_PRE;
        end else begin
            q <= d;
        end
    end

    // Pins and user view, all from flops
    assign link.dev_mdio_o = q.drv_o;
    assign link.dev_mdio_oe = q.drv_oe;
    assign link.irq_pin = q.irq_pin;
    assign phy_control_o = q.regs[PMS_REG_PHY_CTL];

endmodule : pms_dev

//--- rtl/pms_ctl.sv
// Management controller: frames register commands onto the link
`timescale 1ns/1ns
module pms_ctl
    import pms_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, high
    pms_if.ctl_mp link, // Management link
    input wire logic [2:0] addr_i, // Register offset
    input wire logic [15:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [15:0] rdata_o, // Read data, cycle after strobe
    output logic irq_o // Level interrupt
);

    typedef struct packed {
        logic [1:0] mdio_s;
        logic [1:0] irq_s;
        logic irq_prev;
        logic busy;
        logic rd;
        logic mdc;
        logic [3:0] div;
        logic [5:0] bitn;
        logic [63:0] frame;
        logic mdio_o;
        logic mdio_oe;
        logic [15:0] cmd;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [1:0] istat;
        logic [1:0] imask;
        logic pol;
        logic [15:0] bus_rd;
    } pms_ctl_st_t;

    pms_ctl_st_t q;
    pms_ctl_st_t d;

    logic irq_lvl;
    logic done_ev;
    logic [5:0] next_bit;

    // Device interrupt line seen as active, whatever its polarity
    assign irq_lvl = q.pol ? q.irq_s[1] : ~q.irq_s[1];
    assign next_bit = q.bitn + 6'h01;

    always_comb begin
        d = q;
        done_ev = 1'b0;
        d.mdio_s = {q.mdio_s[0], link.mdio};
        d.irq_s = {q.irq_s[0], link.irq_pin};
        d.irq_prev = irq_lvl;
        // Clock runs only during a frame, 4 cycles each phase
        if (q.busy) begin
            d.div = q.div + 4'h1;
            if (q.div == PMS_MDC_HALF - 4'h1) begin
                d.div = 4'h0;
                if (!q.mdc) begin
                    d.mdc = 1'b1;
                    if (q.rd && q.bitn >= PMS_RD_DATA_FIRST) begin
                        d.rdata = {q.rdata[14:0], q.mdio_s[1]};
                    end
                end else begin
                    d.mdc = 1'b0;
                    if (q.bitn == PMS_FRAME_LAST) begin
                        // Frame over: line left undriven
                        d.busy = 1'b0;
                        d.mdio_oe = 1'b0;
                        d.mdio_o = 1'b0;
                        done_ev = 1'b1;
                    end else begin
                        d.bitn = next_bit;
                        d.frame = {q.frame[62:0], 1'b0};
                        d.mdio_o = q.frame[62];
                        // Reads release the line from the first turnaround bit
                        d.mdio_oe = !q.rd || next_bit < PMS_RD_DRV_BITS;
                    end
                end
            end
        end
        // Register writes; commands while busy are dropped
        if (wr_i) begin
            if (addr_i == PMS_H_CMD) begin
                if (!q.busy) begin
                    d.cmd = wdata_i;
                    d.busy = 1'b1;
                    d.rd = wdata_i[PMS_CMD_RD_BIT];
                    d.bitn = 6'h00;
                    d.div = 4'h0;
                    d.mdc = 1'b0;
                    d.mdio_oe = 1'b1;
                    d.mdio_o = 1'b1;
                    if (wdata_i[PMS_CMD_RD_BIT]) begin
                        d.frame = {{PMS_PRE_LEN{1'b1}}, PMS_START, PMS_OP_RD,
                                   wdata_i[9:0], PMS_TA_IDLE, PMS_REG_RST};
                    end else begin
                        d.frame = {{PMS_PRE_LEN{1'b1}}, PMS_START, PMS_OP_WR,
                                   wdata_i[9:0], PMS_TA_WR, q.wdata};
                    end
                end
            end else if (addr_i == PMS_H_WDATA) begin
                d.wdata = wdata_i;
            end else if (addr_i == PMS_H_ISTAT) begin
                d.istat = q.istat & ~wdata_i[1:0];
            end else if (addr_i == PMS_H_IMASK) begin
                d.imask = wdata_i[1:0];
            end else if (addr_i == PMS_H_CFG) begin
                d.pol = wdata_i[0];
            end
        end
        // Events set after the clear so they are never lost
        d.istat[PMS_IS_DONE] = d.istat[PMS_IS_DONE] | done_ev;
        d.istat[PMS_IS_PHY] = d.istat[PMS_IS_PHY] | (irq_lvl & ~q.irq_prev);
        // Read data registered for the cycle after the strobe
        d.bus_rd = 16'h0000;
        if (rd_i) begin
            if (addr_i == PMS_H_CMD) begin
                d.bus_rd = q.cmd;
            end else if (addr_i == PMS_H_WDATA) begin
                d.bus_rd = q.wdata;
            end else if (addr_i == PMS_H_RDATA) begin
                d.bus_rd = q.rdata;
            end else if (addr_i == PMS_H_STATUS) begin
                d.bus_rd = {14'h0000, irq_lvl, q.busy};
            end else if (addr_i == PMS_H_ISTAT) begin
                d.bus_rd = {14'h0000, q.istat};
            end else if (addr_i == PMS_H_IMASK) begin
                d.bus_rd = {14'h0000, q.imask};
            end else if (addr_i == PMS_H_CFG) begin
                d.bus_rd = {15'h0000, q.pol};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.irq_s <= 2'h3; // Idle pin level, so no false edge after reset
        end else begin
            q <= d;
        end
    end

    assign link.mdc = q.mdc;
    assign link.ctl_mdio_o = q.mdio_o;
    assign link.ctl_mdio_oe = q.mdio_oe;
    assign rdata_o = q.bus_rd;
    assign irq_o = |(q.istat & q.imask);

endmodule : pms_ctl

//--- test/pms_assertions.sv
// Checker watching the management link between controller and device
`timescale 1ns/1ns
module pms_assertions (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic mdc, // Management clock
    input wire logic ctl_mdio_o, // Controller drive value
    input wire logic ctl_mdio_oe, // Controller drive enable
    input wire logic dev_mdio_o, // Device drive value
    input wire logic dev_mdio_oe, // Device drive enable
    input wire logic irq_pin, // Device interrupt pin
    input wire logic mdio // Resolved line
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic [7:0] oe_cnt_q;
    logic [7:0] oe_cnt_d;
    // Length of the device drive window; a counter avoids a long repetition
    always_comb oe_cnt_d = dev_mdio_oe ? oe_cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge clk_i) begin
        oe_cnt_q <= rst_i ? 8'h00 : oe_cnt_d;
    end
    one_driver_a: assert property (!(ctl_mdio_oe && dev_mdio_oe))
        else $error("both ends drive the data line");
    clock_high_a: assert property ($rose(mdc) |-> mdc [*4] ##1 !mdc)
        else $error("clock high phase is not four cycles");
    frame_start_a: assert property ($rose(ctl_mdio_oe) |-> (ctl_mdio_o && !mdc) [*4] ##1 mdc)
        else $error("frame does not open with a one bit");
    ctl_setup_a: assert property (ctl_mdio_oe && $changed(ctl_mdio_o) |-> !mdc)
        else $error("controller data changed while clock high");
    dev_setup_a: assert property (dev_mdio_oe && $changed(dev_mdio_o) |-> mdc)
        else $error("device data changed while clock low");
    turn_zero_a: assert property ($rose(dev_mdio_oe) |-> mdc && !dev_mdio_o)
        else $error("device turnaround bit is not zero");
    ctl_release_a: assert property ($rose(dev_mdio_oe) |-> !$past(ctl_mdio_oe, 4))
        else $error("controller still drove at turnaround");
    dev_window_a: assert property ($fell(dev_mdio_oe) |-> oe_cnt_q == 8'h88)
        else $error("device drive window is not seventeen bits");
    idle_free_a: assert property (!mdc [*8] |-> !dev_mdio_oe && mdio)
        else $error("line not released in idle");
    irq_inactive_a: assert property ($fell(rst_i) |-> irq_pin)
        else $error("interrupt pin not inactive low after reset");
endmodule : pms_assertions

//--- test/tb_phy_mgmt_serial_and_irq.sv
// Bench joining controller and device over the management link
`timescale 1ns/1ns
module tb_phy_mgmt_serial_and_irq;
    import pms_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic irq_o;
    logic [2:0] address_strap_pins_i = 3'h1;
    logic [7:0] irq_event_i = 8'h00;
    logic [15:0] phy_control_o;
    logic [15:0] got;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int regs [32] = '{default: 0};
    int ext [8] = '{default: 0};
    int irq_st = 0;
    pms_if link ();
    pms_dev i_pms_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link),
        .address_strap_pins_i(address_strap_pins_i), .irq_event_i(irq_event_i),
        .phy_control_o(phy_control_o));
    pms_ctl i_pms_ctl (.clk_i(clk_i), .rst_i(rst_i), .link(link), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
    pms_assertions i_pms_assertions (.clk_i(clk_i), .rst_i(rst_i), .mdc(link.mdc),
        .ctl_mdio_o(link.ctl_mdio_o), .ctl_mdio_oe(link.ctl_mdio_oe),
        .dev_mdio_o(link.dev_mdio_o), .dev_mdio_oe(link.dev_mdio_oe),
        .irq_pin(link.irq_pin), .mdio(link.mdio));
    always #50 clk_i = ~clk_i;
    // Hang guard: about 75 frames of 512 cycles are expected
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 70000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic bus_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // Let the write land before a caller looks at the outputs
        #1;
    endtask : bus_wr
    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : bus_rd
    // One frame: poll busy with a bound, fetch data, clear the done flag
    task automatic frame(input bit rd, input logic [4:0] phy, input logic [4:0] r,
                         input logic [15:0] d, output logic [15:0] q);
        int n;
        bus_wr(PMS_H_WDATA, d);
        bus_wr(PMS_H_CMD, {rd, 5'h00, phy, r});
        q = 16'h0001;
        for (n = 0; n < 800 && q[0] !== 1'b0; n++) bus_rd(PMS_H_STATUS, q);
        check("busy", 16'(q[0]), 16'h0000);
        bus_rd(PMS_H_RDATA, q);
        bus_wr(PMS_H_ISTAT, 16'h0001);
    endtask : frame
    // Frame to our own device, compared with the register model
    task automatic dev_op(input bit rd, input logic [4:0] r, input logic [15:0] d);
        logic [15:0] q;
        logic [15:0] exp;
        frame(rd, {PMS_PHY_HI, address_strap_pins_i}, r, d, q);
        if (rd) begin
            exp = 16'(regs[r]);
            if (r == PMS_REG_EXT_RD) exp = 16'(ext[regs[11] & 7]);
            if (r == PMS_REG_IRQ) exp = 16'((regs[27] & 'hFF00) | irq_st);
            check("read data", q, exp);
            if (r == PMS_REG_IRQ) irq_st = 0;
        end else if (r != PMS_REG_EXT_RD) begin
            regs[r] = d;
            if (r == PMS_REG_EXT_WR && regs[11][PMS_EXT_WR_BIT]) ext[regs[11] & 7] = d;
        end
    endtask : dev_op
    task automatic pulse(input logic [7:0] ev);
        @(posedge clk_i);
        irq_event_i <= ev;
        @(posedge clk_i);
        irq_event_i <= 8'h00;
        irq_st = irq_st | ev;
        repeat (10) @(posedge clk_i);
    endtask : pulse
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(32'h26d7));
        address_strap_pins_i <= 3'($urandom_range(7, 1));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("pin idle", 16'(link.irq_pin), 16'h0001);
        check("control", phy_control_o, 16'h0000);
        bus_rd(3'h7, got);
        check("unmapped", got, 16'h0000);
        // Random traffic, then every register read back
        for (int k = 0; k < 24; k++) dev_op(1'($urandom), 5'($urandom), 16'($urandom));
        for (int k = 0; k < 32; k++) dev_op(1'b1, 5'(k), 16'h0000);
        $display("register space test done");
        // Indirect access, with and without the write bit
        for (int k = 0; k < 2; k++) begin
            dev_op(1'b0, PMS_REG_EXT_CTL, 16'(k * 'h8000 + k + 2));
            dev_op(1'b0, PMS_REG_EXT_WR, 16'($urandom));
            dev_op(1'b0, PMS_REG_EXT_CTL, 16'(k + 2));
            dev_op(1'b1, PMS_REG_EXT_RD, 16'h0000);
        end
        $display("extended access test done");
        // Foreign addresses must leave the line to its pull-up and register 2 unwritten
        frame(1'b1, {PMS_PHY_HI, address_strap_pins_i ^ 3'h4}, 5'h02, 16'h0000, got);
        check("foreign read", got, 16'hFFFF);
        frame(1'b0, {2'h1, address_strap_pins_i}, 5'h02, 16'h1234, got);
        dev_op(1'b1, 5'h02, 16'h0000);
        $display("address test done");
        // Interrupts, default polarity
        dev_op(1'b0, PMS_REG_PHY_CTL, 16'h0000);
        dev_op(1'b0, PMS_REG_IRQ, 16'h0500);
        bus_wr(PMS_H_IMASK, 16'h0002);
        bus_wr(PMS_H_CFG, 16'h0000);
        bus_rd(PMS_H_IMASK, got);
        check("ctl mask", got, 16'h0002);
        bus_wr(PMS_H_ISTAT, 16'h0003);
        pulse(8'h02);
        check("disabled cond", 16'(link.irq_pin), 16'h0001);
        dev_op(1'b1, PMS_REG_IRQ, 16'h0000);
        pulse(8'($urandom) | 8'h01);
        check("pin active low", 16'(link.irq_pin), 16'h0000);
        check("ctl irq", 16'(irq_o), 16'h0001);
        bus_rd(PMS_H_ISTAT, got);
        check("ctl status", got, 16'h0002);
        dev_op(1'b1, PMS_REG_IRQ, 16'h0000);
        repeat (10) @(posedge clk_i);
        check("pin released", 16'(link.irq_pin), 16'h0001);
        dev_op(1'b1, PMS_REG_IRQ, 16'h0000);
        bus_wr(PMS_H_ISTAT, 16'h0002);
        check("ctl irq clear", 16'(irq_o), 16'h0000);
        // Active high polarity
        dev_op(1'b0, PMS_REG_PHY_CTL, 16'h4000);
        check("control", phy_control_o, 16'h4000);
        check("pin idle high", 16'(link.irq_pin), 16'h0000);
        bus_wr(PMS_H_CFG, 16'h0001);
        bus_wr(PMS_H_ISTAT, 16'h0003);
        pulse(8'h04);
        check("pin active high", 16'(link.irq_pin), 16'h0001);
        check("ctl irq high", 16'(irq_o), 16'h0001);
        bus_rd(PMS_H_STATUS, got);
        check("ctl level", got, 16'h0002);
        bus_rd(PMS_H_CFG, got);
        check("ctl polarity", got, 16'h0001);
        bus_wr(PMS_H_IMASK, 16'h0000);
        check("ctl irq masked", 16'(irq_o), 16'h0000);
        dev_op(1'b1, PMS_REG_IRQ, 16'h0000);
        $display("interrupt test done");
        complete_run();
    end
endmodule : tb_phy_mgmt_serial_and_irq
